//--- crf_cfg.svh
// constants for the core register file and flags block
//------------------------------------------------------------------
// Summary of operation
//------------------------------------------------------------------
// Summary of operation
// (RULE1) program counter clears to zero on reset
// (RULE2) pc steps by length or loads branch target
// (RULE3) stack pointer down on push, up on pop
// (RULE4) swap-all exchanges bc, de, hl with alternates; the code keeps hl in place if swap_hl is set in the same cycle
// (RULE5) hl-only exchange leaves other pairs alone
// (RULE6) accumulator exchange swaps va and wide accumulator
// (RULE7) working address is v high, immediate low
// (RULE8) de/hl pointers step +1, -1 or +2 after access
// (RULE9) status word layout, bits 7 and 1 zero
// (RULE10) interrupt entry pushes status, return restores
// (RULE11) reset clears whole status word
// (RULE12) zero flag follows zero result
// (RULE13) skip flag follows skip condition
// (RULE14) half carry from carry or borrow at bit 3
// (RULE15) acc load chain flag on chained immediate acc loads
// (RULE16) hl load chain flag on chained l/hl loads
// (RULE17) only zero, half carry, carry are testable
// (RULE18) alu does 8/16 bit ops, multiply, divide
// (RULE19) carry from bit 7, or bit 15 when wide
`ifndef CRF_CFG_SVH
`define CRF_CFG_SVH
//------------------------------------------------------------------
// status word field positions and reset values
//------------------------------------------------------------------
`define CRF_SW_ZERO      6
`define CRF_SW_SKIP      5
`define CRF_SW_HALF      4
`define CRF_SW_ACC_CHAIN 3
`define CRF_SW_HL_CHAIN  2
`define CRF_SW_CARRY     0
`define CRF_SW_RESET     8'h00
`define CRF_PC_RESET     16'h0000
`define CRF_SP_RESET     16'h0000
`define CRF_GP_RESET     8'h00
`endif

//--- crf_pkg.sv
// types shared by the core register file and flags block
package crf_pkg;
   // register selectors for 8-bit access
   typedef enum logic [3:0] {
      CRF_R_V = 4'h0, CRF_R_A = 4'h1, CRF_R_B = 4'h2, CRF_R_C = 4'h3,
      CRF_R_D = 4'h4, CRF_R_E = 4'h5, CRF_R_H = 4'h6, CRF_R_L = 4'h7,
      CRF_R_SWL = 4'h8, CRF_R_SWH = 4'h9, CRF_R_EAL = 4'hA,
      CRF_R_EAH = 4'hB, CRF_R_NONE = 4'hF
   } crf_reg_sel_t;
   // pointer pairs
   typedef enum logic [1:0] {
      CRF_P_BC = 2'h0, CRF_P_DE = 2'h1, CRF_P_HL = 2'h2, CRF_P_EA = 2'h3
   } crf_pair_t;
   // pointer post-access step
   typedef enum logic [1:0] {
      CRF_STEP_NONE = 2'h0, CRF_STEP_INC = 2'h1, CRF_STEP_DEC = 2'h2,
      CRF_STEP_INC2 = 2'h3
   } crf_step_t;
   // alu operations
   typedef enum logic [3:0] {
      CRF_ALU_NOP = 4'h0, CRF_ALU_ADD = 4'h1, CRF_ALU_ADC = 4'h2,
      CRF_ALU_SUB = 4'h3, CRF_ALU_SBB = 4'h4, CRF_ALU_AND = 4'h5,
      CRF_ALU_OR = 4'h6, CRF_ALU_XOR = 4'h7, CRF_ALU_SHL = 4'h8,
      CRF_ALU_SHR = 4'h9, CRF_ALU_RLC = 4'hA, CRF_ALU_RRC = 4'hB,
      CRF_ALU_MUL = 4'hC, CRF_ALU_DIV = 4'hD
   } crf_alu_op_t;
   // flag test conditions
   typedef enum logic [1:0] {
      CRF_T_ZERO = 2'h0, CRF_T_HALF = 2'h1, CRF_T_CARRY = 2'h2,
      CRF_T_NONE = 2'h3
   } crf_test_t;
   // program counter sources
   typedef enum logic [1:0] {
      CRF_PC_HOLD = 2'h0, CRF_PC_STEP = 2'h1, CRF_PC_IMM = 2'h2,
      CRF_PC_REG = 2'h3
   } crf_pc_src_t;
   // stack pointer actions
   typedef enum logic [1:0] {
      CRF_SP_HOLD = 2'h0, CRF_SP_DEC = 2'h1, CRF_SP_INC = 2'h2,
      CRF_SP_LOAD = 2'h3
   } crf_sp_act_t;
   // one cycle of control from the sequencer
   typedef struct packed {
      crf_pc_src_t  pc_src;
      logic [2:0]   pc_len;
      logic [15:0]  pc_target;
      crf_sp_act_t  sp_act;
      logic [15:0]  sp_value;
      logic         swap_all;
      logic         swap_hl;
      logic         swap_acc;
      crf_reg_sel_t wr_sel;
      logic [7:0]   wr_data;
      crf_pair_t    ptr_pair;
      crf_step_t    ptr_step;
      crf_alu_op_t  alu_op;
      logic         alu_wide;
      logic [15:0]  alu_b;
      logic         alu_flags;
      logic         alu_write;
      logic         instr_done;
      logic         skip_valid;
      logic         skip_cond;
      logic         acc_chain;
      logic         hl_chain;
      logic         int_entry;
      logic         return_from_interrupt_op;
      logic [7:0]   sw_restore;
      logic [7:0]   work_offset;
      crf_test_t    test_sel;
   } crf_ctrl_t;
   // answer to the sequencer
   typedef struct packed {
      logic [15:0] pc;
      logic [15:0] sp;
      logic [7:0]  status;
      logic [15:0] work_addr;
      logic [15:0] ptr_addr;
      logic [15:0] alu_result;
      logic [7:0]  rd_data;
      logic        test_true;
   } crf_stat_t;
endpackage : crf_pkg

//--- crf_core.sv
// core register file, exchange logic, alu and status word
//
// The plain strobed port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`include "crf_cfg.svh"
module crf_core (
   input  wire logic             clock_i,
   input  wire logic             rst_i,
   input  wire crf_pkg::crf_ctrl_t ctrl_i,
   input  wire crf_pkg::crf_reg_sel_t rd_sel_i,
   output crf_pkg::crf_stat_t    stat_o
);
   import crf_pkg::*;

   //---------------------------------------------------------------
   // storage
   //---------------------------------------------------------------
   // index 0..7 = v a b c d e h l, bank 0 = main, 1 = alternate
   logic [7:0]  gp_reg [0:1][0:7];
   logic [15:0] ea_reg [0:1];
   logic        sel_all_reg;   // bank used by b/c/d/e
   logic        sel_hl_reg;    // bank used by h/l
   logic        sel_acc_reg;   // bank used by v/a/ea
   logic [15:0] pc_reg;
   logic [15:0] sp_reg;
   logic [7:0]  sw_reg;
   logic [7:0]  sw_next;

   //---------------------------------------------------------------
   // active bank views
   //---------------------------------------------------------------
   wire [7:0]  v_w  = gp_reg[sel_acc_reg][0];
   wire [7:0]  a_w  = gp_reg[sel_acc_reg][1];
   wire [7:0]  b_w  = gp_reg[sel_all_reg][2];
   wire [7:0]  c_w  = gp_reg[sel_all_reg][3];
   wire [7:0]  d_w  = gp_reg[sel_all_reg][4];
   wire [7:0]  e_w  = gp_reg[sel_all_reg][5];
   wire [7:0]  h_w  = gp_reg[sel_hl_reg][6];
   wire [7:0]  l_w  = gp_reg[sel_hl_reg][7];
   wire [15:0] ea_w = ea_reg[sel_acc_reg];

   // pointer pair selection
   wire [15:0] bc_w = {b_w, c_w};
   wire [15:0] de_w = {d_w, e_w};
   wire [15:0] hl_w = {h_w, l_w};
   wire [15:0] ptr_w = (ctrl_i.ptr_pair == CRF_P_BC) ? bc_w :
                       (ctrl_i.ptr_pair == CRF_P_DE) ? de_w :
                       (ctrl_i.ptr_pair == CRF_P_HL) ? hl_w : ea_w;
   // post-access step only on de and hl
   wire ptr_stepable = (ctrl_i.ptr_pair == CRF_P_DE) ||
                       (ctrl_i.ptr_pair == CRF_P_HL);
   wire [15:0] ptr_next =
      (ctrl_i.ptr_step == CRF_STEP_INC)  ? ptr_w + 16'h0001 :
      (ctrl_i.ptr_step == CRF_STEP_DEC)  ? ptr_w - 16'h0001 :
      (ctrl_i.ptr_step == CRF_STEP_INC2) ? ptr_w + 16'h0002 :
                                           ptr_w;                // RULE8
   wire ptr_we = ptr_stepable && (ctrl_i.ptr_step != CRF_STEP_NONE);

   //---------------------------------------------------------------
   // alu
   //---------------------------------------------------------------
   logic [16:0] alu_sum;
   logic [15:0] alu_res;
   logic        alu_cy;
   logic        alu_hc;
   logic [4:0]  half_sum;
   logic [15:0] op_a;
   logic        cin;
   logic [15:0] mul_w;
   logic [15:0] div_q;
   logic [7:0]  div_r;

   // divide ea by c, remainder kept in c
   assign mul_w = {8'h00, a_w} * {8'h00, ctrl_i.alu_b[7:0]};
   assign div_q = (c_w == 8'h00) ? 16'hFFFF : ea_w / {8'h00, c_w};
   assign div_r = (c_w == 8'h00) ? c_w : 8'((ea_w % {8'h00, c_w}));

   // combinational operation and flag causes
   always_comb begin
      op_a     = ctrl_i.alu_wide ? ea_w : {8'h00, a_w};
      cin      = (ctrl_i.alu_op == CRF_ALU_ADC ||
                  ctrl_i.alu_op == CRF_ALU_SBB) ? sw_reg[`CRF_SW_CARRY]
                                                : 1'b0;
      alu_sum  = 17'h00000;
      half_sum = 5'h00;
      alu_res  = 16'h0000;
      alu_cy   = 1'b0;
      alu_hc   = 1'b0;
      case (ctrl_i.alu_op)
         CRF_ALU_ADD, CRF_ALU_ADC: begin
            alu_sum  = {1'b0, op_a} + {1'b0, ctrl_i.alu_b}
                       + {16'h0000, cin};
            half_sum = {1'b0, op_a[3:0]} + {1'b0, ctrl_i.alu_b[3:0]}
                       + {4'h0, cin};
         end
         CRF_ALU_SUB, CRF_ALU_SBB: begin
            alu_sum  = {1'b0, op_a} - {1'b0, ctrl_i.alu_b}
                       - {16'h0000, cin};
            half_sum = {1'b0, op_a[3:0]} - {1'b0, ctrl_i.alu_b[3:0]}
                       - {4'h0, cin};
         end
         default: ;
      endcase
      case (ctrl_i.alu_op)
         CRF_ALU_ADD, CRF_ALU_ADC, CRF_ALU_SUB, CRF_ALU_SBB: begin
            alu_res = ctrl_i.alu_wide ? alu_sum[15:0]
                                      : {8'h00, alu_sum[7:0]};
            // carry or borrow at bit 7, or bit 15 when wide
            alu_cy  = ctrl_i.alu_wide ? alu_sum[16]
                                      : alu_sum[8];              // RULE19
            alu_hc  = half_sum[4];                               // RULE14
         end
         CRF_ALU_AND: alu_res = op_a & ctrl_i.alu_b;
         CRF_ALU_OR:  alu_res = op_a | ctrl_i.alu_b;
         CRF_ALU_XOR: alu_res = op_a ^ ctrl_i.alu_b;
         CRF_ALU_SHL: begin
            alu_res = ctrl_i.alu_wide ? {op_a[14:0], 1'b0}
                                      : {8'h00, op_a[6:0], 1'b0};
            alu_cy  = ctrl_i.alu_wide ? op_a[15] : op_a[7];
         end
         CRF_ALU_SHR: begin
            alu_res = {1'b0, op_a[15:1]};
            alu_cy  = op_a[0];
         end
         CRF_ALU_RLC: begin
            alu_res = {8'h00, a_w[6:0], sw_reg[`CRF_SW_CARRY]};
            alu_cy  = a_w[7];
         end
         CRF_ALU_RRC: begin
            alu_res = {8'h00, sw_reg[`CRF_SW_CARRY], a_w[7:1]};
            alu_cy  = a_w[0];
         end
         CRF_ALU_MUL: alu_res = mul_w;                           // RULE18
         CRF_ALU_DIV: alu_res = div_q;                           // RULE18
         default:     alu_res = 16'h0000;
      endcase
   end

   wire alu_zero = ctrl_i.alu_wide ? (alu_res == 16'h0000)
                                   : (alu_res[7:0] == 8'h00);    // RULE12
   wire alu_arith = ctrl_i.alu_op inside {CRF_ALU_ADD, CRF_ALU_ADC,
                    CRF_ALU_SUB, CRF_ALU_SBB};
   wire alu_carry_op = alu_arith ||
      ctrl_i.alu_op inside {CRF_ALU_SHL, CRF_ALU_SHR, CRF_ALU_RLC,
      CRF_ALU_RRC};
   wire mul_div = ctrl_i.alu_op inside {CRF_ALU_MUL, CRF_ALU_DIV};

   //---------------------------------------------------------------
   // status word next value
   //---------------------------------------------------------------
   always_comb begin
      sw_next = sw_reg;
      if (ctrl_i.return_from_interrupt_op) begin
         sw_next = ctrl_i.sw_restore;                            // RULE10
      end else begin
         if (ctrl_i.alu_flags) begin
            sw_next[`CRF_SW_ZERO] = alu_zero;                    // RULE12
            if (alu_arith) sw_next[`CRF_SW_HALF] = alu_hc;       // RULE14
            if (alu_carry_op) sw_next[`CRF_SW_CARRY] = alu_cy;   // RULE19
         end
         if (ctrl_i.skip_valid) begin
            sw_next[`CRF_SW_SKIP] = ctrl_i.skip_cond;            // RULE13
         end
         if (ctrl_i.instr_done) begin
            sw_next[`CRF_SW_ACC_CHAIN] = ctrl_i.acc_chain;       // RULE15
            sw_next[`CRF_SW_HL_CHAIN]  = ctrl_i.hl_chain;        // RULE16
         end
      end
      sw_next[7] = 1'b0;                                         // RULE9
      sw_next[1] = 1'b0;                                         // RULE9
   end

   //---------------------------------------------------------------
   // bank select flip-flops
   //---------------------------------------------------------------
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         sel_all_reg <= 1'b0;
         sel_hl_reg  <= 1'b0;
         sel_acc_reg <= 1'b0;
      end else begin
         // swap-all flips bc and de banks; hl flips when exactly one of swap_all, swap_hl is set
         if (ctrl_i.swap_all) sel_all_reg <= ~sel_all_reg;       // RULE4
         if (ctrl_i.swap_all ^ ctrl_i.swap_hl) begin
            sel_hl_reg <= ~sel_hl_reg;                           // RULE5
         end
         if (ctrl_i.swap_acc) sel_acc_reg <= ~sel_acc_reg;       // RULE6
      end
   end

   //---------------------------------------------------------------
   // general register writes, per bank and per register
   //---------------------------------------------------------------
   genvar gb, gr;
   generate
      for (gb = 0; gb < 2; gb++) begin : g_bank
         for (gr = 0; gr < 8; gr++) begin : g_reg
            wire [0:0] bank_of = (gr < 2) ? sel_acc_reg :
                                 (gr < 6) ? sel_all_reg : sel_hl_reg;
            wire active = (bank_of == 1'(gb));
            wire hit_wr = active && (ctrl_i.wr_sel == crf_reg_sel_t'(gr));
            wire hit_ptr = active && ptr_we &&
               (((gr == 4 || gr == 5) && ctrl_i.ptr_pair == CRF_P_DE) ||
                ((gr == 6 || gr == 7) && ctrl_i.ptr_pair == CRF_P_HL));
            wire hit_alu = active && ctrl_i.alu_write &&
               ((gr == 1) || (gr == 3 && ctrl_i.alu_op == CRF_ALU_DIV));
            wire [7:0] ptr_byte = (gr % 2 == 0) ? ptr_next[15:8]
                                                : ptr_next[7:0];
            wire [7:0] alu_byte = (gr == 3) ? div_r : alu_res[7:0];
            always_ff @(posedge clock_i or posedge rst_i) begin
               if (rst_i) begin
                  gp_reg[gb][gr] <= `CRF_GP_RESET;
               end else if (hit_alu && !ctrl_i.alu_wide && !mul_div) begin
                  gp_reg[gb][gr] <= alu_byte;
               end else if (hit_alu && gr == 3) begin
                  gp_reg[gb][gr] <= alu_byte;
               end else if (hit_ptr) begin
                  gp_reg[gb][gr] <= ptr_byte;                    // RULE8
               end else if (hit_wr) begin
                  gp_reg[gb][gr] <= ctrl_i.wr_data;
               end
            end
         end
         // wide accumulator of this bank
         wire ea_act = (sel_acc_reg == 1'(gb));
         always_ff @(posedge clock_i or posedge rst_i) begin
            if (rst_i) begin
               ea_reg[gb] <= {`CRF_GP_RESET, `CRF_GP_RESET};
            end else if (ea_act && ctrl_i.alu_write &&
                         (ctrl_i.alu_wide || mul_div)) begin
               ea_reg[gb] <= alu_res;                            // RULE18
            end else if (ea_act && ctrl_i.wr_sel == CRF_R_EAL) begin
               ea_reg[gb] <= {ea_reg[gb][15:8], ctrl_i.wr_data};
            end else if (ea_act && ctrl_i.wr_sel == CRF_R_EAH) begin
               ea_reg[gb] <= {ctrl_i.wr_data, ea_reg[gb][7:0]};
            end
         end
      end
   endgenerate

   //---------------------------------------------------------------
   // program counter, stack pointer and status word
   //---------------------------------------------------------------
   wire [15:0] pc_next =
      (ctrl_i.pc_src == CRF_PC_STEP) ? pc_reg + {13'h0000, ctrl_i.pc_len} :
      (ctrl_i.pc_src == CRF_PC_IMM)  ? ctrl_i.pc_target :
      (ctrl_i.pc_src == CRF_PC_REG)  ? ptr_w : pc_reg;           // RULE2
   wire [15:0] sp_next =
      (ctrl_i.sp_act == CRF_SP_DEC)  ? sp_reg - 16'h0001 :
      (ctrl_i.sp_act == CRF_SP_INC)  ? sp_reg + 16'h0001 :
      (ctrl_i.sp_act == CRF_SP_LOAD) ? ctrl_i.sp_value : sp_reg; // RULE3

   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         pc_reg <= `CRF_PC_RESET;                                // RULE1
         sp_reg <= `CRF_SP_RESET;
         sw_reg <= `CRF_SW_RESET;                                // RULE11
      end else begin
         pc_reg <= pc_next;
         sp_reg <= sp_next;
         sw_reg <= sw_next;
      end
   end

   //---------------------------------------------------------------
   // read port, address forming and flag test
   //---------------------------------------------------------------
   logic [7:0] rd_next;
   always_comb begin
      case (rd_sel_i)
         CRF_R_V:   rd_next = v_w;
         CRF_R_A:   rd_next = a_w;
         CRF_R_B:   rd_next = b_w;
         CRF_R_C:   rd_next = c_w;
         CRF_R_D:   rd_next = d_w;
         CRF_R_E:   rd_next = e_w;
         CRF_R_H:   rd_next = h_w;
         CRF_R_L:   rd_next = l_w;
         // status byte pushed on interrupt entry
         CRF_R_SWL: rd_next = sw_reg;                            // RULE10
         CRF_R_EAL: rd_next = ea_w[7:0];
         CRF_R_EAH: rd_next = ea_w[15:8];
         default:   rd_next = 8'h00;
      endcase
   end

   logic [7:0] rd_reg;
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) rd_reg <= 8'h00;
      else       rd_reg <= rd_next;
   end

   // only zero, half carry and carry can be tested
   wire test_w = (ctrl_i.test_sel == CRF_T_ZERO)  ? sw_reg[`CRF_SW_ZERO] :
                 (ctrl_i.test_sel == CRF_T_HALF)  ? sw_reg[`CRF_SW_HALF] :
                 (ctrl_i.test_sel == CRF_T_CARRY) ? sw_reg[`CRF_SW_CARRY]
                                                  : 1'b0;        // RULE17

   assign stat_o.pc         = pc_reg;
   assign stat_o.sp         = sp_reg;
   assign stat_o.status     = sw_reg;
   assign stat_o.work_addr  = {v_w, ctrl_i.work_offset};         // RULE7
   assign stat_o.ptr_addr   = ptr_w;
   assign stat_o.alu_result = alu_res;
   assign stat_o.rd_data    = rd_reg;
   assign stat_o.test_true  = test_w;
endmodule : crf_core

//--- crf_core_sva.sv
// port assertions for the register file core
`timescale 1ns/1ps
module crf_core_sva (
   input wire logic                  clock_i,
   input wire logic                  rst_i,
   input wire crf_pkg::crf_ctrl_t    ctrl_i,
   input wire crf_pkg::crf_reg_sel_t rd_sel_i,
   input wire crf_pkg::crf_stat_t    stat_o
);
   import crf_pkg::*;
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (rst_i);
   sequence s_two_dec;
      ctrl_i.sp_act == CRF_SP_DEC ##1 ctrl_i.sp_act == CRF_SP_DEC;
   endsequence
   //------------------------------------------------------------
   // assertions
   //------------------------------------------------------------
   chk_reset_clear: assert property (
      disable iff (1'b0) rst_i |-> stat_o.pc == 16'h0000
      && stat_o.status == 8'h00) else $error("state not cleared by reset");
   chk_pc_step: assert property (
      ctrl_i.pc_src == CRF_PC_STEP |=> stat_o.pc ==
      $past(stat_o.pc) + 16'($past(ctrl_i.pc_len)))
      else $error("pc did not step by length");
   chk_pc_branch: assert property (
      ctrl_i.pc_src == CRF_PC_IMM |=> stat_o.pc == $past(ctrl_i.pc_target))
      else $error("pc did not load branch target");
   chk_sp_down: assert property (
      ctrl_i.sp_act == CRF_SP_DEC |=> stat_o.sp == $past(stat_o.sp) - 16'h0001)
      else $error("sp did not decrement");
   chk_sp_word: assert property (
      s_two_dec |=> stat_o.sp == $past(stat_o.sp, 2) - 16'h0002)
      else $error("word push did not lower sp by two");
   chk_sp_up: assert property (
      ctrl_i.sp_act == CRF_SP_INC |=> stat_o.sp == $past(stat_o.sp) + 16'h0001)
      else $error("sp did not increment");
   chk_work_addr: assert property (
      stat_o.work_addr[7:0] == ctrl_i.work_offset)
      else $error("working address low byte wrong");
   chk_sw_fixed: assert property (
      stat_o.status[7] == 1'b0 && stat_o.status[1] == 1'b0)
      else $error("fixed status bits not zero");
   chk_sw_restore: assert property (
      ctrl_i.return_from_interrupt_op |=> stat_o.status == ($past(ctrl_i.sw_restore) & 8'h7D))
      else $error("status not restored");
   chk_skip_flag: assert property (
      ctrl_i.skip_valid && !ctrl_i.return_from_interrupt_op |=>
      stat_o.status[5] == $past(ctrl_i.skip_cond))
      else $error("skip flag wrong");
   chk_chain_flags: assert property (
      ctrl_i.instr_done && !ctrl_i.return_from_interrupt_op |=> stat_o.status[3:2] ==
      {$past(ctrl_i.acc_chain), $past(ctrl_i.hl_chain)})
      else $error("load chain flags wrong");
   chk_zero_flag: assert property (
      ctrl_i.alu_flags && !ctrl_i.alu_wide && !ctrl_i.return_from_interrupt_op &&
      ctrl_i.alu_op == CRF_ALU_ADD |=> stat_o.status[6] ==
      ($past(stat_o.alu_result[7:0]) == 8'h00))
      else $error("zero flag wrong");
   chk_test_carry: assert property (
      ctrl_i.test_sel == CRF_T_CARRY |-> stat_o.test_true == stat_o.status[0])
      else $error("carry test wrong");
endmodule : crf_core_sva

bind crf_core crf_core_sva i_sva (
   .clock_i  (clock_i),
   .rst_i    (rst_i),
   .ctrl_i   (ctrl_i),
   .rd_sel_i (rd_sel_i),
   .stat_o   (stat_o)
);

//--- crf_seq_model.sv
// sequencer model that issues control words and register reads
`timescale 1ns/1ps
module crf_seq_model (
   input  wire logic            clock_i,
   output crf_pkg::crf_ctrl_t   ctrl_o,
   output crf_pkg::crf_reg_sel_t rd_sel_o
);
   import crf_pkg::*;
   // idle word
   function automatic crf_ctrl_t idle_word();
      crf_ctrl_t w;
      w = '0;
      w.wr_sel = CRF_R_NONE;
      return w;
   endfunction : idle_word
   initial begin
      ctrl_o = idle_word();
      rd_sel_o = CRF_R_NONE;
   end
   // hold a word for n edges, then fall back to idle
   task automatic issue(input crf_ctrl_t w, input int n);
      @(posedge clock_i);
      ctrl_o <= w;
      repeat (n) @(posedge clock_i);
      ctrl_o <= idle_word();
   endtask : issue
   // one read select for one edge
   task automatic read(input crf_reg_sel_t s);
      @(posedge clock_i);
      rd_sel_o <= s;
      @(posedge clock_i);
      rd_sel_o <= CRF_R_NONE;
   endtask : read
endmodule : crf_seq_model

//--- crf_core_tb.sv
// self-checking bench for the register file core
`timescale 1ns/1ps
module crf_core_tb;
   import crf_pkg::*;
   logic         clock_i;
   logic         rst_i;
   crf_ctrl_t    ctrl;
   crf_reg_sel_t rd_sel;
   crf_stat_t    stat;
   crf_stat_t    seen;
   crf_ctrl_t    c;
   logic [7:0]   mv [12];
   logic [7:0]   av [12];
   logic [7:0]   q8 [$];
   logic [15:0]  ex;
   logic [15:0]  hl;
   logic         rd_pend = 1'b0;
   int           err_count = 0;
   int           samples_checked = 0;
   int           cycles = 0;
   int           i;
   int           j;
   integer       seed;
   // op, a, b, result, status
   logic [39:0]  alu_tab [5] = '{40'h010F011010, 40'h01FF010051,
                                 40'h0310010F10, 40'h030001FF11,
                                 40'h0120305000};
   // skip valid/cond, done, acc/hl chain, masked status
   logic [15:0]  fl_tab [4] = '{16'h1820, 16'h0628, 16'h0524, 16'h1004};
   //------------------------------------------------------------
   // clock, design, sequencer model
   //------------------------------------------------------------
   initial begin
      clock_i = 1'b0;
      forever #5 clock_i = ~clock_i;
   end
   crf_core i_dut (.clock_i(clock_i), .rst_i(rst_i), .ctrl_i(ctrl),
                   .rd_sel_i(rd_sel), .stat_o(stat));
   crf_seq_model i_seq (.clock_i(clock_i), .ctrl_o(ctrl), .rd_sel_o(rd_sel));
   //------------------------------------------------------------
   // tasks
   //------------------------------------------------------------
   task automatic test_done();
      if (err_count == 0 && samples_checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : test_done
   task automatic cmp(input logic [15:0] g, input logic [15:0] e);
      samples_checked++;
      if (g !== e) begin
         err_count++;
         $display("unexpected at %0t: got %h expected %h", $time, g, e);
      end
   endtask : cmp
   // issue c for n edges
   task automatic go(input int n);
      i_seq.issue(c, n);
      @(negedge clock_i);
   endtask : go
   task automatic wr(input crf_reg_sel_t s, input logic [7:0] d);
      crf_ctrl_t w;
      w = i_seq.idle_word();
      w.wr_sel = s;
      w.wr_data = d;
      i_seq.issue(w, 1);
      @(negedge clock_i);
   endtask : wr
   // note the expected byte, then read
   task automatic rd(input crf_reg_sel_t s, input logic [7:0] e);
      q8.push_back(e);
      i_seq.read(s);
   endtask : rd
   // sample the combinational answer
   task automatic probe();
      fork
         i_seq.issue(c, 1);
         begin
            @(posedge clock_i);
            @(negedge clock_i);
            seen = stat;
         end
      join
   endtask : probe
   // read data watcher and hang guard
   always @(posedge clock_i) rd_pend <= (rd_sel !== CRF_R_NONE);
   always @(negedge clock_i) begin
      if (rd_pend) begin
         cmp(stat.rd_data, q8.pop_front());
      end
   end
   always @(posedge clock_i) begin
      cycles++;
      if (cycles == 4000) begin
         err_count++;
         test_done();
      end
   end
   //------------------------------------------------------------
   // main sequence
   //------------------------------------------------------------
   initial begin
      seed = 32'h1A9A5CBB;
      rst_i = 1'b1;
      repeat (4) @(posedge clock_i);
      rst_i <= 1'b0;
      @(negedge clock_i);
      cmp(stat.pc, 16'h0000);
      cmp(stat.status, 8'h00);
      for (i = 0; i < 12; i++) begin
         mv[i] = 8'($random(seed));
         av[i] = 8'($random(seed));
         if (i < 8 || i > 9) begin
            wr(crf_reg_sel_t'(i), mv[i]);
         end
      end
      c = i_seq.idle_word();
      c.swap_all = 1'b1;
      go(1);
      for (i = 2; i < 8; i++) begin
         rd(crf_reg_sel_t'(i), 8'h00);
         wr(crf_reg_sel_t'(i), av[i]);
      end
      go(1);
      for (i = 0; i < 8; i++) begin
         rd(crf_reg_sel_t'(i), mv[i]);
      end
      c.swap_all = 1'b0;
      c.swap_hl = 1'b1;
      go(1);
      for (i = 2; i < 8; i++) begin
         rd(crf_reg_sel_t'(i), (i > 5) ? av[i] : mv[i]);
      end
      go(1);
      c = i_seq.idle_word();
      c.swap_acc = 1'b1;
      for (j = 0; j < 2; j++) begin
         go(1);
         for (i = 0; i < 12; i++) begin
            if (i < 2 || i > 9) begin
               rd(crf_reg_sel_t'(i), (j == 1) ? mv[i] : 8'h00);
            end
         end
      end
      c = i_seq.idle_word();
      c.work_offset = 8'($random(seed));
      probe();
      cmp(seen.work_addr, {mv[0], c.work_offset});
      hl = {mv[6], mv[7]};
      c.ptr_pair = CRF_P_HL;
      for (i = 1; i < 5; i++) begin
         c.ptr_step = crf_step_t'(i & 3);
         probe();
         cmp(seen.ptr_addr, hl);
         hl = hl + ((i == 1) ? 16'h0001 : (i == 2) ? 16'hFFFF : 16'h0002);
      end
      ex = 16'h0000;
      c = i_seq.idle_word();
      c.ptr_pair = CRF_P_HL;
      for (i = 1; i < 4; i++) begin
         c.pc_src = CRF_PC_STEP;
         c.pc_len = 3'(i);
         go(1);
         ex = ex + 16'(i);
         cmp(stat.pc, ex);
      end
      c.pc_src = CRF_PC_IMM;
      c.pc_target = 16'($random(seed));
      go(1);
      cmp(stat.pc, c.pc_target);
      c.pc_src = CRF_PC_REG;
      go(1);
      cmp(stat.pc, hl - 16'h0002);
      c = i_seq.idle_word();
      c.sp_act = CRF_SP_LOAD;
      c.sp_value = 16'($random(seed));
      go(1);
      c.sp_act = CRF_SP_DEC;
      go(2);
      cmp(stat.sp, c.sp_value - 16'h0002);
      c.sp_act = CRF_SP_INC;
      go(1);
      cmp(stat.sp, c.sp_value - 16'h0001);
      c = i_seq.idle_word();
      c.return_from_interrupt_op = 1'b1;
      c.sw_restore = 8'hFF;
      go(1);
      cmp(stat.status, 8'h7D);
      c.sw_restore = 8'h00;
      go(1);
      cmp(stat.status, 8'h00);
      for (i = 0; i < 5; i++) begin
         wr(CRF_R_A, alu_tab[i][31:24]);
         c = i_seq.idle_word();
         c.alu_op = crf_alu_op_t'(alu_tab[i][35:32]);
         c.alu_b = {8'h00, alu_tab[i][23:16]};
         c.alu_write = 1'b1;
         c.alu_flags = 1'b1;
         go(1);
         cmp(stat.status, alu_tab[i][7:0]);
         rd(CRF_R_A, alu_tab[i][15:8]);
      end
      wr(CRF_R_EAL, 8'hFF);
      wr(CRF_R_EAH, 8'hFF);
      c.alu_wide = 1'b1;
      c.alu_op = CRF_ALU_ADD;
      c.alu_b = 16'h0001;
      go(1);
      cmp(stat.status & 8'h41, 8'h41);
      rd(CRF_R_EAH, 8'h00);
      c = i_seq.idle_word();
      for (i = 0; i < 3; i += 2) begin
         c.test_sel = crf_test_t'(i);
         probe();
         cmp({7'h00, seen.test_true}, 8'h01);
      end
      for (i = 0; i < 4; i++) begin
         c = i_seq.idle_word();
         {c.skip_valid, c.skip_cond, c.instr_done, c.acc_chain,
          c.hl_chain} = fl_tab[i][12:8];
         go(1);
         cmp(stat.status & 8'h2C, fl_tab[i][7:0]);
      end
      repeat (3) @(posedge clock_i);
      test_done();
   end
endmodule : crf_core_tb
